// >>> design/smbus_monitor_regs.svh
// register offsets, field positions, reset values and timing counts of the voltage monitor
`ifndef SMBUS_MONITOR_REGS_SVH
`define SMBUS_MONITOR_REGS_SVH
// ==================================================
// bus addresses
`define OWN_ADDR        7'h2e
`define ALERT_RESP_ADDR 7'h0c
// ==================================================
// register offsets
`define OFS_CHIP_READ   8'h21
`define OFS_OWN_READ    8'h22
`define OFS_CONFIG_ONE  8'h40
`define OFS_STATUS      8'h41
`define OFS_CHIP_LOW    8'h46
`define OFS_CHIP_HIGH   8'h47
`define OFS_CHAN_SEL    8'h55
`define OFS_CONFIG_TWO  8'h73
`define OFS_EXT_ONE     8'h76
`define OFS_EXT_TWO     8'h77
// ==================================================
// field positions
`define BIT_LOCK        1
`define BIT_TIMEOUT_DIS 6
`define BIT_AVG_OFF     4
`define BIT_ATTEN_BYP   5
`define BIT_SINGLE      6
`define BIT_STAT_LOW    0
`define BIT_STAT_HIGH   1
`define EXT_CHIP_LSB    0
`define EXT_OWN_LSB     2
`define CHAN_SEL_LSB    5
// ==================================================
// reset values and channel codes
`define RST_READING     8'h00
`define RST_CHIP_LOW    8'h00
`define RST_CHIP_HIGH   8'hff
`define RST_CONFIG      8'h00
`define CHAN_CHIP       3'h1
`define CHAN_OWN        3'h2
// ==================================================
// timing
`define CLK_PERIOD_NS   40
`define CONV_TIME_NS    711000
`define CONV_CYCLES     ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMEOUT_NS      35000000
`define TIMEOUT_CYCLES  (`TIMEOUT_NS / `CLK_PERIOD_NS)
`endif

// >>> design/smbus_monitor_pkg.sv
// types shared by the voltage monitor modules
`default_nettype none
package smbus_monitor_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX_BITS, ST_RX_END, ST_ACK_SLOT, ST_TX_BITS, ST_TX_ACK, ST_WAIT_STOP
   } link_state_type;
   typedef enum logic [1:0] {BYTE_ADDR, BYTE_CMD, BYTE_DATA} byte_kind_type;
endpackage
`default_nettype wire

// >>> design/meas_if.sv
// measurement settings and results between register file and sequencer
`default_nettype none
interface meas_if;
   logic       avgOff;
   logic       singleMode;
   logic [2:0] singleChan;
   logic       resultValid;
   logic [2:0] resultChan;
   logic [9:0] resultCode;
   modport seq  (input avgOff, singleMode, singleChan,
                 output resultValid, resultChan, resultCode);
   modport regs (output avgOff, singleMode, singleChan,
                 input resultValid, resultChan, resultCode);
endinterface
`default_nettype wire

// >>> design/smbus_line_watch.sv
// bus line event detector and bus silence timeout
`include "smbus_monitor_regs.svh"
`default_nettype none
module smbus_line_watch #(
   parameter logic [19:0] TIMEOUT_CYCLES = 20'(`TIMEOUT_CYCLES)
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // bus lines
   input  wire logic sclIn,
   input  wire logic sdaIn,
   // transaction state
   input  wire logic busy,
   input  wire logic timeoutEnable,
   // line events
   output logic      sclRise,
   output logic      sclFall,
   output logic      startSeen,
   output logic      stopSeen,
   output logic      timeoutSeen
);
   logic        sclPrev_reg;
   logic        sdaPrev_reg;
   logic [19:0] idle_reg;
   logic [19:0] idle_next;

   // ==================================================
   // silence counter, only while a transaction is open
   always_comb begin
      idle_next = 20'h00000;
      if (busy && sclIn == sclPrev_reg && sdaIn == sdaPrev_reg) begin
         idle_next = (idle_reg == TIMEOUT_CYCLES) ? idle_reg : idle_reg + 20'h00001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclPrev_reg <= 1'b1;
         sdaPrev_reg <= 1'b1;
         idle_reg    <= 20'h00000;
      end else begin
         sclPrev_reg <= sclIn;
         sdaPrev_reg <= sdaIn;
         idle_reg    <= idle_next;
      end
   end

   assign sclRise     = sclIn & ~sclPrev_reg;
   assign sclFall     = ~sclIn & sclPrev_reg;
   assign startSeen   = sclIn & sclPrev_reg & sdaPrev_reg & ~sdaIn;
   assign stopSeen    = sclIn & sclPrev_reg & ~sdaPrev_reg & sdaIn;
   assign timeoutSeen = timeoutEnable & busy & (idle_reg == TIMEOUT_CYCLES);
endmodule
`default_nettype wire

// >>> design/adc_sequencer.sv
// conversion slot timer, channel scan and sixteen sample averaging
`include "smbus_monitor_regs.svh"
`default_nettype none
module adc_sequencer #(
   parameter logic [14:0] CONV_CYCLES = 15'(`CONV_CYCLES)
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // settings and results
   meas_if.seq             meas,
   // converter
   output logic            adcStart,
   output logic [2:0]      adcChannel,
   input  wire logic [9:0] adcData
);
   logic [14:0] slot_reg,  slot_next;
   logic [3:0]  count_reg, count_next;
   logic [13:0] acc_reg,   acc_next;
   logic [2:0]  chan_reg,  chan_next;
   logic        valid_reg, valid_next;
   logic [2:0]  rchan_reg, rchan_next;
   logic [9:0]  code_reg,  code_next;
   logic [13:0] sum;

   // ==================================================
   // one conversion per slot; data is taken in the slot's last cycle
   always_comb begin
      sum        = acc_reg + {4'h0, adcData};
      slot_next  = slot_reg + 15'h0001;
      count_next = count_reg;
      acc_next   = acc_reg;
      chan_next  = chan_reg;
      valid_next = 1'b0;
      rchan_next = rchan_reg;
      code_next  = code_reg;
      if (slot_reg == CONV_CYCLES - 15'h0001) begin
         slot_next = 15'h0000;
         if (meas.avgOff || count_reg == 4'hf) begin
            valid_next = 1'b1;
            rchan_next = chan_reg;
            code_next  = meas.avgOff ? adcData : sum[13:4];
            acc_next   = 14'h0000;
            count_next = 4'h0;
            // single mode repeats the chosen input, else chipset and own supply alternate
            if (meas.singleMode) begin
               chan_next = meas.singleChan;
            end else begin
               chan_next = (chan_reg == `CHAN_CHIP) ? `CHAN_OWN : `CHAN_CHIP;
            end
         end else begin
            acc_next   = sum;
            count_next = count_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_reg  <= 15'h0000;
         count_reg <= 4'h0;
         acc_reg   <= 14'h0000;
         chan_reg  <= `CHAN_CHIP;
         valid_reg <= 1'b0;
         rchan_reg <= `CHAN_CHIP;
         code_reg  <= 10'h000;
      end else begin
         slot_reg  <= slot_next;
         count_reg <= count_next;
         acc_reg   <= acc_next;
         chan_reg  <= chan_next;
         valid_reg <= valid_next;
         rchan_reg <= rchan_next;
         code_reg  <= code_next;
      end
   end

   assign adcStart         = (slot_reg == 15'h0000);
   assign adcChannel       = chan_reg;
   assign meas.resultValid = valid_reg;
   assign meas.resultChan  = rchan_reg;
   assign meas.resultCode  = code_reg;
endmodule
`default_nettype wire

// >>> design/smbus_voltage_monitor_control.sv
// voltage monitor top: bus slave protocol, register file and limit checks
`include "smbus_monitor_regs.svh"
`default_nettype none
module smbus_voltage_monitor_control #(
   parameter logic [19:0] TIMEOUT_CYCLES = 20'(`TIMEOUT_CYCLES),
   parameter logic [14:0] CONV_CYCLES    = 15'(`CONV_CYCLES)
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // serial bus, open drain
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   // alert line, open drain
   output logic            alertOut,
   output logic            alertOe,
   // converter
   output logic            adcStart,
   output logic [2:0]      adcChannel,
   output logic            adcAttenBypass,
   input  wire logic [9:0] adcData
);
   // ==================================================
   // protocol state
   smbus_monitor_pkg::link_state_type state_reg, state_next;
   smbus_monitor_pkg::byte_kind_type  kind_reg,  kind_next;
   logic [2:0] cnt_reg,   cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] ptr_reg,   ptr_next;
   logic       drive_reg, drive_next;
   logic       read_reg,  read_next;
   logic       ara_reg,   ara_next;
   logic       wrEn;
   logic       rdEn;

   // ==================================================
   // register file state
   logic [7:0] cfgOne_reg,   cfgOne_next;
   logic [7:0] cfgTwo_reg,   cfgTwo_next;
   logic [7:0] chanSel_reg,  chanSel_next;
   logic [7:0] lowLim_reg,   lowLim_next;
   logic [7:0] highLim_reg,  highLim_next;
   logic [7:0] chipRead_reg, chipRead_next;
   logic [7:0] ownRead_reg,  ownRead_next;
   logic [7:0] extOne_reg,   extOne_next;
   logic [7:0] status_reg,   status_next;
   logic       freezeChip_reg, freezeChip_next;
   logic       freezeOwn_reg,  freezeOwn_next;
   logic [7:0] rdData;
   logic       alertActive;

   // ==================================================
   // line events
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic timeoutSeen;

   smbus_line_watch #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) lineWatch (
      .clk           (clk),
      .rst           (rst),
      .sclIn         (sclIn),
      .sdaIn         (sdaIn),
      .busy          (state_reg != smbus_monitor_pkg::ST_IDLE),
      .timeoutEnable (~cfgOne_reg[`BIT_TIMEOUT_DIS]),
      .sclRise       (sclRise),
      .sclFall       (sclFall),
      .startSeen     (startSeen),
      .stopSeen      (stopSeen),
      .timeoutSeen   (timeoutSeen)
   );

   // ==================================================
   // measurement sequencer
   meas_if meas ();

   adc_sequencer #(.CONV_CYCLES(CONV_CYCLES)) sequencer (
      .clk        (clk),
      .rst        (rst),
      .meas       (meas.seq),
      .adcStart   (adcStart),
      .adcChannel (adcChannel),
      .adcData    (adcData)
   );

   assign meas.avgOff     = cfgTwo_reg[`BIT_AVG_OFF];
   assign meas.singleMode = cfgTwo_reg[`BIT_SINGLE];
   assign meas.singleChan = chanSel_reg[`CHAN_SEL_LSB +: 3];
   // the attenuator switch only concerns the chipset input
   assign adcAttenBypass  = cfgTwo_reg[`BIT_ATTEN_BYP] && adcChannel == `CHAN_CHIP;

   // ==================================================
   // read data selected by the pointer
   always_comb begin
      case (ptr_reg)
         `OFS_CHIP_READ:  rdData = chipRead_reg;
         `OFS_OWN_READ:   rdData = ownRead_reg;
         `OFS_CONFIG_ONE: rdData = cfgOne_reg;
         `OFS_STATUS:     rdData = status_reg;
         `OFS_CHIP_LOW:   rdData = lowLim_reg;
         `OFS_CHIP_HIGH:  rdData = highLim_reg;
         `OFS_CHAN_SEL:   rdData = chanSel_reg;
         `OFS_CONFIG_TWO: rdData = cfgTwo_reg;
         `OFS_EXT_ONE:    rdData = extOne_reg;
         default:         rdData = 8'h00;
      endcase
   end

   // ==================================================
   // byte level protocol
   always_comb begin
      state_next = state_reg;
      kind_next  = kind_reg;
      cnt_next   = cnt_reg;
      shift_next = shift_reg;
      ptr_next   = ptr_reg;
      drive_next = drive_reg;
      read_next  = read_reg;
      ara_next   = ara_reg;
      wrEn       = 1'b0;
      rdEn       = 1'b0;
      if (timeoutSeen || stopSeen) begin
         state_next = smbus_monitor_pkg::ST_IDLE;
         drive_next = 1'b0;
      end else if (startSeen) begin
         // a repeated start opens a new address phase from any point
         state_next = smbus_monitor_pkg::ST_RX_BITS;
         kind_next  = smbus_monitor_pkg::BYTE_ADDR;
         cnt_next   = 3'h0;
         drive_next = 1'b0;
      end else begin
         unique case (state_reg)
            smbus_monitor_pkg::ST_IDLE, smbus_monitor_pkg::ST_WAIT_STOP: begin
            end
            smbus_monitor_pkg::ST_RX_BITS: begin
               if (sclRise) begin
                  shift_next = {shift_reg[6:0], sdaIn};
                  cnt_next   = cnt_reg + 3'h1;
                  if (cnt_reg == 3'h7) begin
                     state_next = smbus_monitor_pkg::ST_RX_END;
                  end
               end
            end
            smbus_monitor_pkg::ST_RX_END: begin
               if (sclFall) begin
                  state_next = smbus_monitor_pkg::ST_ACK_SLOT;
                  drive_next = 1'b1;
                  unique case (kind_reg)
                     smbus_monitor_pkg::BYTE_ADDR: begin
                        read_next = shift_reg[0];
                        ara_next  = 1'b0;
                        if (shift_reg[7:1] == `OWN_ADDR) begin
                           ara_next = 1'b0;
                        end else if (shift_reg[7:1] == `ALERT_RESP_ADDR && shift_reg[0]
                                     && alertActive) begin
                           ara_next = 1'b1;
                        end else begin
                           drive_next = 1'b0;
                           state_next = smbus_monitor_pkg::ST_WAIT_STOP;
                        end
                     end
                     smbus_monitor_pkg::BYTE_CMD: begin
                        ptr_next = shift_reg;
                     end
                     smbus_monitor_pkg::BYTE_DATA: begin
                        wrEn = 1'b1;
                     end
                  endcase
               end
            end
            smbus_monitor_pkg::ST_ACK_SLOT: begin
               if (sclFall) begin
                  cnt_next   = 3'h0;
                  drive_next = 1'b0;
                  state_next = smbus_monitor_pkg::ST_RX_BITS;
                  if (kind_reg == smbus_monitor_pkg::BYTE_ADDR && read_reg) begin
                     // read side effects happen when the byte is loaded for sending
                     shift_next = ara_reg ? {`OWN_ADDR, 1'b0} : rdData;
                     rdEn       = ~ara_reg;
                     drive_next = ~shift_next[7];
                     state_next = smbus_monitor_pkg::ST_TX_BITS;
                  end else if (kind_reg == smbus_monitor_pkg::BYTE_ADDR) begin
                     kind_next = smbus_monitor_pkg::BYTE_CMD;
                  end else if (kind_reg == smbus_monitor_pkg::BYTE_CMD) begin
                     kind_next = smbus_monitor_pkg::BYTE_DATA;
                  end else begin
                     state_next = smbus_monitor_pkg::ST_WAIT_STOP;
                  end
               end
            end
            smbus_monitor_pkg::ST_TX_BITS: begin
               if (sclRise) begin
                  cnt_next = cnt_reg + 3'h1;
                  // released a one but the line reads low: another sender wins
                  if (!drive_reg && !sdaIn) begin
                     state_next = smbus_monitor_pkg::ST_WAIT_STOP;
                  end
               end else if (sclFall) begin
                  if (cnt_reg == 3'h0) begin
                     drive_next = 1'b0;
                     state_next = smbus_monitor_pkg::ST_TX_ACK;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     drive_next = ~shift_reg[6];
                  end
               end
            end
            smbus_monitor_pkg::ST_TX_ACK: begin
               // only one byte is offered; the master's nack or ack ends it
               if (sclRise) begin
                  state_next = smbus_monitor_pkg::ST_WAIT_STOP;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= smbus_monitor_pkg::ST_IDLE;
         kind_reg  <= smbus_monitor_pkg::BYTE_ADDR;
         cnt_reg   <= 3'h0;
         shift_reg <= 8'h00;
         ptr_reg   <= 8'h00;
         drive_reg <= 1'b0;
         read_reg  <= 1'b0;
         ara_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         kind_reg  <= kind_next;
         cnt_reg   <= cnt_next;
         shift_reg <= shift_next;
         ptr_reg   <= ptr_next;
         drive_reg <= drive_next;
         read_reg  <= read_next;
         ara_reg   <= ara_next;
      end
   end

   // ==================================================
   // register file, limit checks and freezing
   always_comb begin
      cfgOne_next     = cfgOne_reg;
      cfgTwo_next     = cfgTwo_reg;
      chanSel_next    = chanSel_reg;
      lowLim_next     = lowLim_reg;
      highLim_next    = highLim_reg;
      chipRead_next   = chipRead_reg;
      ownRead_next    = ownRead_reg;
      extOne_next     = extOne_reg;
      status_next     = status_reg;
      freezeChip_next = freezeChip_reg;
      freezeOwn_next  = freezeOwn_reg;
      // locked writes were acknowledged on the bus but change nothing
      if (wrEn && !cfgOne_reg[`BIT_LOCK]) begin
         case (ptr_reg)
            `OFS_CONFIG_ONE: cfgOne_next  = shift_reg;
            `OFS_CONFIG_TWO: cfgTwo_next  = shift_reg;
            `OFS_CHAN_SEL:   chanSel_next = shift_reg;
            `OFS_CHIP_LOW:   lowLim_next  = shift_reg;
            `OFS_CHIP_HIGH:  highLim_next = shift_reg;
            default: begin
            end
         endcase
      end
      cfgOne_next[`BIT_LOCK] = cfgOne_next[`BIT_LOCK] | cfgOne_reg[`BIT_LOCK];
      if (rdEn) begin
         case (ptr_reg)
            `OFS_STATUS:    status_next = 8'h00;
            `OFS_EXT_ONE: begin
               freezeChip_next = 1'b1;
               freezeOwn_next  = 1'b1;
            end
            `OFS_CHIP_READ: freezeChip_next = 1'b0;
            `OFS_OWN_READ:  freezeOwn_next  = 1'b0;
            default: begin
            end
         endcase
      end
      // a result landing with a status read still sets its bit
      if (meas.resultValid && meas.resultChan == `CHAN_CHIP) begin
         if (meas.resultCode[9:2] < lowLim_reg) begin
            status_next[`BIT_STAT_LOW] = 1'b1;
         end
         if (meas.resultCode[9:2] > highLim_reg) begin
            status_next[`BIT_STAT_HIGH] = 1'b1;
         end
         if (!freezeChip_reg) begin
            chipRead_next                   = meas.resultCode[9:2];
            extOne_next[`EXT_CHIP_LSB +: 2] = meas.resultCode[1:0];
         end
      end
      if (meas.resultValid && meas.resultChan == `CHAN_OWN && !freezeOwn_reg) begin
         ownRead_next                   = meas.resultCode[9:2];
         extOne_next[`EXT_OWN_LSB +: 2] = meas.resultCode[1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfgOne_reg     <= `RST_CONFIG;
         cfgTwo_reg     <= `RST_CONFIG;
         chanSel_reg    <= `RST_CONFIG;
         lowLim_reg     <= `RST_CHIP_LOW;
         highLim_reg    <= `RST_CHIP_HIGH;
         chipRead_reg   <= `RST_READING;
         ownRead_reg    <= `RST_READING;
         extOne_reg     <= `RST_READING;
         status_reg     <= 8'h00;
         freezeChip_reg <= 1'b0;
         freezeOwn_reg  <= 1'b0;
      end else begin
         cfgOne_reg     <= cfgOne_next;
         cfgTwo_reg     <= cfgTwo_next;
         chanSel_reg    <= chanSel_next;
         lowLim_reg     <= lowLim_next;
         highLim_reg    <= highLim_next;
         chipRead_reg   <= chipRead_next;
         ownRead_reg    <= ownRead_next;
         extOne_reg     <= extOne_next;
         status_reg     <= status_next;
         freezeChip_reg <= freezeChip_next;
         freezeOwn_reg  <= freezeOwn_next;
      end
   end

   // ==================================================
   // open drain outputs
   assign alertActive = |status_reg;
   assign alertOut    = 1'b0;
   assign alertOe     = alertActive;
   assign sdaOut      = 1'b0;
   assign sdaOe       = drive_reg;
endmodule
`default_nettype wire

// >>> test/smbus_monitor_checker.sv
// port assertions for the voltage monitor
`default_nettype none
module smbus_monitor_checker #(
   parameter logic [19:0] TIMEOUT_CYCLES = 20'hd59f8,
   parameter logic [14:0] CONV_CYCLES    = 15'h456f
) (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // serial bus
   input wire logic       sclIn,
   input wire logic       sdaIn,
   input wire logic       sdaOut,
   input wire logic       sdaOe,
   // alert line
   input wire logic       alertOut,
   input wire logic       alertOe,
   // converter
   input wire logic       adcStart,
   input wire logic       adcAttenBypass,
   input wire logic [2:0] adcChannel,
   input wire logic [9:0] adcData
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====
   // slot counter, since a long repetition would crawl
   logic [14:0] slot_reg, slot_next;
   always_comb slot_next = adcStart ? 15'h1 : slot_reg + 15'h1;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_reg <= 15'h0;
      end else begin
         slot_reg <= slot_next;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence slotPulse; adcStart ##1 !adcStart; endsequence
   drive_low_a: assert property ({sdaOut, alertOut} == 2'h0)
      else $error("line high");
   start_pulse_a: assert property (adcStart |-> slotPulse)
      else $error("long start");
   slot_period_a: assert property (adcStart && slot_reg != 15'h0 |->
      slot_reg == CONV_CYCLES) else $error("slot length");
   scl_low_drive_a: assert property ($changed(sdaOe) |-> !sclIn && !$past(sclIn))
      else $error("data moved");
   bypass_chipset_a: assert property (adcAttenBypass |-> adcChannel == 3'h1)
      else $error("bypass off chipset");
   channel_at_slot_a: assert property ($changed(adcChannel) |->
      adcStart || $past(adcStart)) else $error("channel moved");
   alert_by_read_a: assert property ($fell(alertOe) |-> !sclIn)
      else $error("alert dropped");
   alert_on_result_a: assert property ($rose(alertOe) |->
      $past(adcStart) || $past(adcStart, 2) || $past(adcStart, 3) || $past(adcStart, 4))
      else $error("alert unprompted");
endmodule
bind smbus_voltage_monitor_control smbus_monitor_checker #(
   .TIMEOUT_CYCLES (TIMEOUT_CYCLES),
   .CONV_CYCLES    (CONV_CYCLES)
) u_chk (
   .clk            (clk),
   .rst            (rst),
   .sclIn          (sclIn),
   .sdaIn          (sdaIn),
   .sdaOut         (sdaOut),
   .sdaOe          (sdaOe),
   .alertOut       (alertOut),
   .alertOe        (alertOe),
   .adcStart       (adcStart),
   .adcAttenBypass (adcAttenBypass),
   .adcChannel     (adcChannel),
   .adcData        (adcData)
);
`default_nettype wire

// >>> test/smbus_master_model.sv
// bus master model: clock line and its side of the data line
`default_nettype none
module smbus_master_model (
   input  wire logic clk,
   input  wire logic sdaOe,
   output var logic  sclIn,
   output wire logic sdaIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv = 1'h1;
   initial sclIn = 1'h1;
   // released line floats high through the pull-up
   assign sdaIn = drv & ~sdaOe;
   // three clocks between changes, as the slave finds edges by sampling
   task automatic gap; repeat (3) @(negedge clk); endtask
   // start when s is high, stop when low
   task automatic cond(input logic s);
      drv = s; gap; sclIn = 1'h1; gap; drv = ~s; gap; sclIn = ~s; gap;
   endtask
   task automatic bitx(input logic b, output logic v);
      drv = b; gap; sclIn = 1'h1; gap; v = sdaIn; gap; sclIn = 1'h0; gap;
   endtask
   task automatic tr(input logic [23:0] b, input int n, input logic fin,
                     output logic [8:0] r, output logic nk);
      logic v;
      cond(1'h1);
      for (int k = 0; k < n; k++) begin
         for (int i = 8; i >= 0; i--) begin
            bitx((i == 0) || b[15 + i - 8 * k], v);
            r = {r[7:0], v};
         end
         if (k == 0) nk = r[0];
      end
      if (fin) cond(1'h0);
   endtask
endmodule
`default_nettype wire

// >>> test/smbus_voltage_monitor_control_tb.sv
// self-checking bench for the voltage monitor
`default_nettype none
module smbus_voltage_monitor_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'h0, rst = 1'h1, sclIn, sdaIn, sdaOut, sdaOe, alertOut, alertOe, nk;
   logic       adcStart, adcAttenBypass;
   logic [2:0] adcChannel;
   logic [9:0] adcData;
   logic [8:0] r;
   logic [9:0] chipCode = 10'h301;
   int         bad_count = 0, checks = 0, cycles = 0;
   assign adcData = (adcChannel == 3'h1) ? chipCode : 10'h2fe;
   always #20 clk = ~clk;
   smbus_master_model u_m (.clk(clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
   smbus_voltage_monitor_control #(.TIMEOUT_CYCLES(20'hc8), .CONV_CYCLES(15'h14)) u_dut (
      .clk            (clk),
      .rst            (rst),
      .sclIn          (sclIn),
      .sdaIn          (sdaIn),
      .sdaOut         (sdaOut),
      .sdaOe          (sdaOe),
      .alertOut       (alertOut),
      .alertOe        (alertOe),
      .adcStart       (adcStart),
      .adcChannel     (adcChannel),
      .adcAttenBypass (adcAttenBypass),
      .adcData        (adcData)
   );
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t(input logic [23:0] b, input int n, input logic fin);
      u_m.tr(b, n, fin, r, nk);
   endtask
   task automatic w(input int n); repeat (n) @(negedge clk); endtask
   task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
      t({8'h5c, ofs, 8'h0}, 2, 1'h1);
      t(24'h5dff00, 2, 1'h1);
      check(r[8:1], exp);
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
      t({8'h5c, ofs, dat}, 3, 1'h1);
      check({7'h0, r[0]}, 8'h0);
   endtask
   // ceiling well above the roughly 14000 cycles the tests take
   always @(negedge clk) if (++cycles == 40000) begin
      bad_count++;
      stop_test;
   end
   initial begin
      w(2);
      rst = 1'h0;
      w(2);
      rd(8'h47, 8'hff);
      wr(8'h46, 8'h10);
      rd(8'h46, 8'h10);
      t(24'h5dff00, 2, 1'h1);
      check(r[8:1], 8'h10);
      t(24'h5e0000, 1, 1'h1);
      check({7'h0, nk}, 8'h1);
      t(24'h5d0000, 1, 1'h0);
      check({7'h0, sdaOe}, 8'h1);
      w(210);
      check({7'h0, sdaOe}, 8'h0);
      u_m.cond(1'h0);
      $display("bus test done");
      w(1400);
      rd(8'h76, 8'h09);
      // a new chipset level must not reach the frozen reading
      chipCode = 10'h2c0;
      w(700);
      rd(8'h21, 8'hc0);
      w(700);
      rd(8'h21, 8'hb0);
      chipCode = 10'h301;
      wr(8'h47, 8'hbf);
      w(1400);
      t(24'h19ff00, 2, 1'h1);
      check(r[8:1], 8'h5c);
      // a lower bit from another sender makes the reply give way
      t(24'h195a00, 2, 1'h1);
      check(r[8:1], 8'h5a);
      wr(8'h47, 8'hff);
      w(1400);
      check({7'h0, alertOe}, 8'h1);
      rd(8'h41, 8'h02);
      check({7'h0, alertOe}, 8'h0);
      $display("measure test done");
      wr(8'h55, 8'h40);
      wr(8'h73, 8'h50);
      w(100);
      check({5'h0, adcChannel}, 8'h02);
      wr(8'h55, 8'h20);
      wr(8'h73, 8'h70);
      check({7'h0, adcAttenBypass}, 8'h1);
      // with the timeout off a stalled read keeps its data bit
      wr(8'h40, 8'h40);
      t(24'h5d0000, 1, 1'h0);
      w(210);
      check({7'h0, sdaOe}, 8'h1);
      repeat (9) u_m.bitx(1'h1, nk);
      u_m.cond(1'h0);
      wr(8'h40, 8'h02);
      wr(8'h46, 8'h33);
      rd(8'h46, 8'h10);
      $display("mode test done");
      stop_test;
   end
endmodule
`default_nettype wire
